// ---- bench/nds_chk.sv ----
// nds_chk: timing and ownership checks on the flash bus between host and die
// assumes one mclk domain and that it sits beside the bus interface instance
`default_nettype none
module nds_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // bus levels
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic wr_n,
    input wire logic wp_n,
    input wire logic host_dq_oe,
    input wire logic [7:0] dev_dq_o,
    input wire logic dev_dq_oe,
    input wire logic dqs
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // one host write strobe and one stretch of synchronous status output
    sequence we_pulse;
        (!we_n)[*5] ##1 we_n;
    endsequence
    sequence sync_show;
        (!ce_n && !wr_n && ale && cle && dev_dq_oe)[*3];
    endsequence
    ////////////////////////////////////////
    chk_no_contention: assert property (!(host_dq_oe && dev_dq_oe))
        else $error("host and die drive dq together");
    chk_idle_release: assert property (ce_n[*6] |-> !dev_dq_oe)
        else $error("die drives dq with chip enable high");
    chk_drive_window: assert property ($rose(dev_dq_oe) |-> !ce_n && (!re_n || (ale && cle)))
        else $error("die starts driving outside a read window");
    chk_reserved_zero: assert property (dev_dq_oe |-> dev_dq_o[4:2] == 3'b000)
        else $error("reserved status bits not zero");
    chk_wp_mirror: assert property (dev_dq_oe && $stable(wp_n) && $past(wp_n, 2) == wp_n
        && $past(wp_n, 3) == wp_n && $past(wp_n, 4) == wp_n
        |-> dev_dq_o[7] == wp_n) else $error("status bit 7 differs from write protect");
    chk_dqs_toggle: assert property (sync_show |-> $changed(dqs))
        else $error("dqs still during synchronous status output");
    chk_dqs_quiet: assert property (ce_n[*6] |-> $stable(dqs))
        else $error("dqs moves while chip enable high");
    chk_strobe_shape: assert property ($fell(we_n) |-> we_pulse)
        else $error("write strobe not five cycles low");
    chk_strobe_owner: assert property (!we_n |-> host_dq_oe && !ce_n)
        else $error("write strobe without host driving dq");
endmodule : nds_chk
`default_nettype wire

// ---- bench/test_nds_die_status_reporting.sv ----
// test_nds_die_status_reporting: host and die joined, host driven over avalon-mm
// assumes every bus sequence is launched through the host command register
`default_nettype none
module test_nds_die_status_reporting;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic die_busy = 1'b0;
    logic [1:0] plane_busy = 2'h0;
    logic [1:0] plane_start = 2'h0;
    logic [1:0] plane_done = 2'h0;
    logic [1:0] plane_fail = 2'h0;
    logic [31:0] rd;
    logic [31:0] r;
    logic die_sel;
    logic [7:0] sbyte;
    logic [7:0] ccode;
    logic [23:0] raddr;
    int errors = 0;
    int checks_done = 0;
    int seed = 32'heaa8;
    int rec[2] = '{0, 0};
    int prv[2] = '{0, 0};
    int wp = 1;
    nds_bus_if bus ();
    // 250 MHz clock
    always #2 mclk = ~mclk;
    ////////////////////////////////////////
    nds_die #(.NUM_PLANES(2), .SINGLE_DIE(1'b0), .DIE_ID(1'b0)) u_nds_die (.mclk(mclk),
        .resetn(resetn), .bus(bus), .die_busy(die_busy), .plane_busy(plane_busy),
        .plane_start(plane_start), .plane_done(plane_done), .plane_fail(plane_fail),
        .otp_mode(1'b0), .otp_prot_violation(1'b0), .cmd_valid(), .cmd_code(ccode),
        .row_addr(raddr), .die_selected(die_sel), .status_byte(sbyte));
    nds_host u_nds_host (.mclk(mclk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .bus(bus));
    nds_chk u_nds_chk (.mclk(mclk), .resetn(resetn), .ce_n(bus.ce_n), .cle(bus.cle),
        .ale(bus.ale), .we_n(bus.we_n), .re_n(bus.re_n), .wr_n(bus.wr_n), .wp_n(bus.wp_n),
        .host_dq_oe(bus.host_dq_oe), .dev_dq_o(bus.dev_dq_o), .dev_dq_oe(bus.dev_dq_oe),
        .dqs(bus.dqs));
    ////////////////////////////////////////
    // expected status byte; p below zero means errors ored over both planes
    function automatic logic [7:0] model(input int p);
        logic [1:0] e;
        if (p < 0) e = {1'(prv[0] | prv[1]), 1'(rec[0] | rec[1])};
        else e = {1'(prv[p]), 1'(rec[p])};
        return {1'(wp), ~die_busy, ~|plane_busy, 3'b000, e};
    endfunction : model
    // error bits only count while the matching ready flag is high
    function automatic logic [7:0] msk();
        return {6'h3f, ~die_busy, ~|plane_busy};
    endfunction : msk
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (exp !== got) begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : cmp
    // one avalon transfer, held until waitrequest is seen low
    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 5000);
        if (n >= 5000) cmp("waitrequest timeout", 32'h0000_0000, 32'h0000_0001);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : av
    // launch a command with one byte read, poll until done, compare the byte
    task automatic stat_rd(input logic [31:0] c, input logic [23:0] row, input logic [7:0] e,
                           input logic [7:0] m);
        av(1'b1, nds_pkg::REG_ROW, {8'h00, row});
        av(1'b1, nds_pkg::REG_CMD, c);
        rd = 32'h0000_0001;
        for (int i = 0; i < 60 && rd[0] !== 1'b0; i++) av(1'b0, nds_pkg::REG_STAT, 32'h0);
        if (rd[0] !== 1'b0) cmp("sequence busy", 32'h0000_0000, {31'h0, rd[0]});
        cmp("status byte", {24'h0, e & m}, {24'h0, rd[15:8] & m});
    endtask : stat_rd
    // both planes start and finish together with the given fail pattern
    task automatic plane_op(input logic [1:0] f);
        @(posedge mclk);
        plane_start <= 2'h3;
        plane_busy <= 2'h3;
        @(posedge mclk);
        plane_start <= 2'h0;
        @(posedge mclk);
        plane_done <= 2'h3;
        plane_fail <= f;
        plane_busy <= 2'h0;
        @(posedge mclk);
        plane_done <= 2'h0;
        for (int p = 0; p < 2; p++) begin
            prv[p] = rec[p];
            rec[p] = f[p];
        end
    endtask : plane_op
    task automatic wrap_up();
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////
    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        resetn <= 1'b1;
        av(1'b1, 4'h1, 32'h0000_000b);
        av(1'b0, nds_pkg::REG_MODE, 32'h0);
        cmp("mode", 32'h0000_0004, rd);
        av(1'b0, nds_pkg::REG_STAT, 32'h0);
        cmp("stat", 32'h0000_0000, rd);
        av(1'b0, 4'h1, 32'h0);
        cmp("unmapped", 32'h0000_0000, rd);
        for (int k = 0; k < 12; k++) begin
            r = $random(seed);
            wp = r[0];
            die_busy <= r[1];
            plane_busy <= r[3:2];
            av(1'b1, nds_pkg::REG_MODE, {28'h0, 1'b0, r[0], 1'b0, r[4]});
            stat_rd(32'h0000_0270, 24'h0, model(-1), msk());
        end
        die_busy <= 1'b0;
        plane_busy <= 2'h0;
        wp = 1;
        av(1'b1, nds_pkg::REG_MODE, 32'h0000_0004);
        plane_op(2'h2);
        plane_op(2'h1);
        stat_rd(32'h0000_0270, 24'h00_0000, model(-1), 8'hff);
        cmp("live status", {24'h0, model(-1)}, {24'h0, sbyte});
        stat_rd(32'h0000_0378, 24'h00_0000, model(0), 8'hff);
        stat_rd(32'h0000_0378, 24'h00_0100, model(1), 8'hff);
        stat_rd(32'h0000_0378, 24'h10_0000, 8'hff, 8'hff);
        cmp("selected", 32'h0000_0000, {31'h0, die_sel});
        cmp("row", 32'h0010_0000, {8'h00, raddr});
        stat_rd(32'h0000_0270, 24'h00_0000, 8'hff, 8'hff);
        stat_rd(32'h0000_0378, 24'h00_0000, model(0), 8'hff);
        cmp("selected", 32'h0000_0001, {31'h0, die_sel});
        die_busy <= 1'b1;
        @(posedge mclk);
        stat_rd(32'h0000_0200, 24'h00_0000, model(0), msk());
        die_busy <= 1'b0;
        @(posedge mclk);
        stat_rd(32'h0000_0200, 24'h00_0000, 8'hff, 8'hff);
        av(1'b1, nds_pkg::REG_MODE, 32'h0000_0006);
        av(1'b1, nds_pkg::REG_CMD, 32'h0000_0270);
        av(1'b0, nds_pkg::REG_STAT, 32'h0);
        cmp("refused 70h", 32'h0000_0002, rd & 32'h0000_0007);
        av(1'b1, nds_pkg::REG_CMD, 32'h0000_00ff);
        av(1'b1, nds_pkg::REG_CMD, 32'h0000_0378);
        av(1'b0, nds_pkg::REG_STAT, 32'h0);
        cmp("refused", 32'h0000_0006, rd & 32'h0000_0007);
        cmp("last command", 32'h0000_00ff, {24'h0, ccode});
        wrap_up();
    end
    // watchdog against a hung handshake
    initial begin
        #200000;
        errors++;
        wrap_up();
    end
endmodule : test_nds_die_status_reporting
`default_nettype wire

// ---- include/nds_bus_if.sv ----
// nds_bus_if: flash bus between host controller and one die
// assumes both ends run on mclk; dq is resolved here from the two enables
`default_nettype none
interface nds_bus_if;
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic wr_n;
    logic wp_n;
    logic [7:0] host_dq_o;
    logic host_dq_oe;
    logic [7:0] dev_dq_o;
    logic dev_dq_oe;
    logic dqs;
    logic [7:0] dq;

    // pulled high when nobody drives
    assign dq = host_dq_oe ? host_dq_o : (dev_dq_oe ? dev_dq_o : nds_pkg::BUS_IDLE);

    modport dev (
        input ce_n, cle, ale, we_n, re_n, wr_n, wp_n, dq,
        output dev_dq_o, dev_dq_oe, dqs
    );
    modport host (
        input dq, dqs,
        output ce_n, cle, ale, we_n, re_n, wr_n, wp_n, host_dq_o, host_dq_oe
    );
endinterface : nds_bus_if
`default_nettype wire

// ---- include/nds_pkg.sv ----
// nds_pkg: constants shared by the die status end and the host controller end
// assumes a single 250 MHz clock shared by both ends of the flash bus
`default_nettype none
package nds_pkg;
    // opcodes seen on the bus
    localparam logic [7:0] CMD_READ_MODE = 8'h00;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_READ_STATUS_ENH = 8'h78;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    localparam logic [7:0] CMD_SYNC_RESET = 8'hFC;
    // status byte layout
    localparam int SB_WP = 7;
    localparam int SB_DIE_IDLE = 6;
    localparam int SB_ARRAY_IDLE = 5;
    localparam int SB_PREV_ERR = 1;
    localparam int SB_RECENT_ERR = 0;
    localparam logic [7:0] SB_RESET = 8'h00;
    // row address layout: three bytes, low byte first
    localparam int ROW_CYCLES = 3;
    localparam int ROW_W = 24;
    localparam int PLANE_ROW_BIT = 8;
    localparam int DIE_ROW_BIT = 20;
    localparam logic [7:0] BUS_IDLE = 8'hFF;
    // bus timing: strobe half period and read window
    localparam int CLK_PERIOD_NS = 4;
    localparam int STROBE_T_NS = 20;
    localparam int READ_T_NS = 40;
    localparam int STROBE_CYC = (STROBE_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC = (READ_T_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // host register map (byte addresses)
    localparam int AV_ADDR_W = 4;
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ROW = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_MODE = 4'hC;
    // command register fields
    localparam int CMDF_WITH_ADDR = 8;
    localparam int CMDF_DO_READ = 9;
    // mode register fields
    localparam int MODEF_SYNC = 0;
    localparam int MODEF_MULTI_LUN = 1;
    localparam int MODEF_WP_N = 2;
    localparam int MODEF_OTP = 3;
    // status register fields
    localparam int STATF_BUSY = 0;
    localparam int STATF_REFUSED = 1;
    localparam int STATF_RESET_LOCK = 2;
    localparam int STATF_BYTE_LO = 8;
endpackage : nds_pkg
`default_nettype wire

// ---- verilog/nds_die.sv ----
// nds_die: status reporting logic of one die on a multi-die flash target
// assumes bus pins arrive unsynchronised and array events come from mclk logic
`default_nettype none
module nds_die #(
    parameter int NUM_PLANES = 2,
    parameter bit SINGLE_DIE = 1'b1,
    parameter bit DIE_ID = 1'b0
) (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // flash bus
    nds_bus_if.dev bus,
    // array side events
    input wire logic die_busy,
    input wire logic [NUM_PLANES-1:0] plane_busy,
    input wire logic [NUM_PLANES-1:0] plane_start,
    input wire logic [NUM_PLANES-1:0] plane_done,
    input wire logic [NUM_PLANES-1:0] plane_fail,
    input wire logic otp_mode,
    input wire logic otp_prot_violation,
    // decoded commands, selection and status byte for the array side
    output logic cmd_valid,
    output logic [7:0] cmd_code,
    output logic [nds_pkg::ROW_W-1:0] row_addr,
    output logic die_selected,
    output logic [7:0] status_byte
);
    localparam int PSEL_W = (NUM_PLANES > 1) ? $clog2(NUM_PLANES) : 1;
    localparam int PIN_W = 7;
    localparam int P_CE = 6;
    localparam int P_CLE = 5;
    localparam int P_ALE = 4;
    localparam int P_WE = 3;
    localparam int P_RE = 2;
    localparam int P_WR = 1;
    localparam int P_WP = 0;

    typedef enum logic [1:0] {ST_IDLE, ST_ADDR78, ST_STATUS} nds_die_st_type;

    typedef struct packed {
        logic [PIN_W-1:0] pin_s1;
        logic [PIN_W-1:0] pin_s2;
        logic [7:0] dq_s1;
        logic [7:0] dq_s2;
        logic we_d;
        nds_die_st_type st;
        logic sel;
        logic st78;
        logic [1:0] addr_cnt;
        logic [nds_pkg::ROW_W-1:0] row;
        logic [PSEL_W-1:0] plane;
        logic [NUM_PLANES-1:0] active;
        logic [NUM_PLANES-1:0] recent_err;
        logic [NUM_PLANES-1:0] prev_err;
        logic otp_fail;
        logic [7:0] sbyte;
        logic [7:0] dq_o;
        logic dq_oe;
        logic dqs;
        logic cmd_valid;
        logic [7:0] cmd_code;
    } nds_die_state_type;

    nds_die_state_type st_r;
    nds_die_state_type st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [PIN_W-1:0] pin;
        logic we_rise;
        logic [7:0] din;
        logic array_idle;
        logic die_idle;
        logic prev_bit;
        logic recent_bit;
        logic show_async;
        logic show_sync;
        logic [nds_pkg::ROW_W-1:0] row_new;
        prev_bit = 1'b0;
        recent_bit = 1'b0;
        show_async = 1'b0;
        show_sync = 1'b0;
        pin = st_r.pin_s2;
        din = st_r.dq_s2;
        we_rise = pin[P_WE] & ~st_r.we_d & ~pin[P_CE];
        array_idle = ~|plane_busy;
        die_idle = ~die_busy;
        row_new = {din, st_r.row[nds_pkg::ROW_W-1:8]};
        st_nxt = st_r;
        // two-stage synchronisers on every bus input
        st_nxt.pin_s1 = {bus.ce_n, bus.cle, bus.ale, bus.we_n, bus.re_n, bus.wr_n, bus.wp_n};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.dq_s1 = bus.dq;
        st_nxt.dq_s2 = st_r.dq_s1;
        st_nxt.we_d = pin[P_WE];
        st_nxt.cmd_valid = 1'b0;

        // command and address cycles, latched on the write strobe rising
        if (we_rise && pin[P_CLE]) begin
            unique case (din)
                nds_pkg::CMD_RESET, nds_pkg::CMD_SYNC_RESET: begin
                    // reset commands pass even while busy
                    st_nxt.st = ST_IDLE;
                    st_nxt.cmd_valid = st_r.sel;
                    st_nxt.cmd_code = din;
                end
                nds_pkg::CMD_READ_STATUS: begin
                    if (st_r.sel || SINGLE_DIE) begin
                        st_nxt.st = ST_STATUS;
                        st_nxt.st78 = 1'b0;
                    end
                end
                nds_pkg::CMD_READ_STATUS_ENH: begin
                    // every die takes the address, busy or not
                    st_nxt.st = ST_ADDR78;
                    st_nxt.addr_cnt = '0;
                end
                default: begin
                    // other commands only reach an idle, selected die
                    if (die_idle && st_r.sel) begin
                        st_nxt.st = ST_IDLE;
                        st_nxt.cmd_valid = 1'b1;
                        st_nxt.cmd_code = din;
                    end
                end
            endcase
        end else if (we_rise && pin[P_ALE]) begin
            if (st_r.st == ST_ADDR78 || die_idle) begin
                st_nxt.row = row_new;
            end
            if (st_r.st == ST_ADDR78) begin
                st_nxt.addr_cnt = st_r.addr_cnt + 2'd1;
                if (st_r.addr_cnt == 2'(nds_pkg::ROW_CYCLES - 1)) begin
                    // addressed die enters status mode, others leave the bus
                    st_nxt.sel = SINGLE_DIE | (row_new[nds_pkg::DIE_ROW_BIT] == DIE_ID);
                    st_nxt.st = (st_nxt.sel) ? ST_STATUS : ST_IDLE;
                    st_nxt.st78 = 1'b1;
                    st_nxt.plane = row_new[nds_pkg::PLANE_ROW_BIT +: PSEL_W];
                end
            end
        end

        // active plane set: restarts when the array was idle
        if (|plane_start) begin
            st_nxt.active = array_idle ? plane_start : (st_r.active | plane_start);
        end
        // per-plane pass/fail history
        for (int p = 0; p < NUM_PLANES; p++) begin
            if (plane_done[p]) begin
                st_nxt.prev_err[p] = st_r.recent_err[p];
                st_nxt.recent_err[p] = plane_fail[p];
            end
        end
        // otp protect failure: set wins over leaving otp mode
        if (otp_prot_violation) begin
            st_nxt.otp_fail = 1'b1;
        end else if (!otp_mode) begin
            st_nxt.otp_fail = 1'b0;
        end

        // error bits: ORed over active planes, or one plane after 78h
        if (st_r.st78) begin
            prev_bit = st_r.prev_err[st_r.plane];
            recent_bit = st_r.recent_err[st_r.plane];
        end else begin
            prev_bit = |(st_r.prev_err & st_r.active);
            recent_bit = |(st_r.recent_err & st_r.active);
        end
        st_nxt.sbyte = nds_pkg::SB_RESET;
        st_nxt.sbyte[nds_pkg::SB_WP] = otp_mode ? ~st_r.otp_fail : pin[P_WP];
        st_nxt.sbyte[nds_pkg::SB_DIE_IDLE] = die_idle;
        st_nxt.sbyte[nds_pkg::SB_ARRAY_IDLE] = array_idle;
        st_nxt.sbyte[nds_pkg::SB_PREV_ERR] = prev_bit;
        st_nxt.sbyte[nds_pkg::SB_RECENT_ERR] = recent_bit;

        // live output of status while the strobes stay in place
        show_async = (st_r.st == ST_STATUS) & ~pin[P_CE] & ~pin[P_RE]
            & pin[P_WR] & ~(pin[P_ALE] & pin[P_CLE]);
        show_sync = (st_r.st == ST_STATUS) & ~pin[P_CE] & ~pin[P_WR]
            & pin[P_ALE] & pin[P_CLE];
        st_nxt.dq_oe = show_async | show_sync;
        st_nxt.dq_o = st_r.sbyte;
        st_nxt.dqs = show_sync ? ~st_r.dqs : 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '0;
            st_r.pin_s1 <= '1;
            st_r.pin_s2 <= '1;
            st_r.we_d <= 1'b1;
            st_r.sel <= 1'b1;
            st_r.st <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign bus.dev_dq_o = st_r.dq_o;
    assign bus.dev_dq_oe = st_r.dq_oe;
    assign bus.dqs = st_r.dqs;
    assign cmd_valid = st_r.cmd_valid;
    assign cmd_code = st_r.cmd_code;
    assign row_addr = st_r.row;
    assign die_selected = st_r.sel;
    assign status_byte = st_r.sbyte;
endmodule : nds_die
`default_nettype wire

// ---- verilog/nds_host.sv ----
// nds_host: flash host controller end, driven from Avalon-MM registers
// assumes one die on the bus; dq from the die is resynchronised, dqs is not used
`default_nettype none
module nds_host (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [nds_pkg::AV_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // flash bus
    nds_bus_if.host bus
);
    typedef enum logic [1:0] {H_IDLE, H_CMD, H_ADDR, H_READ} nds_host_st_type;

    typedef struct packed {
        logic [7:0] dq_s1;
        logic [7:0] dq_s2;
        nds_host_st_type st;
        logic [nds_pkg::CNT_W-1:0] cnt;
        logic half;
        logic [1:0] idx;
        logic [7:0] cmd;
        logic with_addr;
        logic do_read;
        logic [nds_pkg::ROW_W-1:0] row;
        logic [3:0] mode;
        logic refused;
        logic reset_lock;
        logic [7:0] last_byte;
        logic rd_ack;
        logic [31:0] rdata;
        logic ce_n;
        logic cle;
        logic ale;
        logic we_n;
        logic re_n;
        logic wr_n;
        logic [7:0] dq_o;
        logic dq_oe;
    } nds_host_state_type;

    nds_host_state_type h_r;
    nds_host_state_type h_nxt;
    logic busy;
    logic cmd_stall;

    assign busy = (h_r.st != H_IDLE);
    assign cmd_stall = avs_write & (avs_address == nds_pkg::REG_CMD) & busy;
    // reads take one wait cycle, command writes wait for an idle bus
    assign avs_waitrequest = cmd_stall | (avs_read & ~h_r.rd_ack);

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic strobe_end;
        logic refuse;
        logic [7:0] c;
        refuse = 1'b0;
        c = avs_writedata[7:0];
        strobe_end = (h_r.cnt == '0);
        h_nxt = h_r;
        h_nxt.dq_s1 = bus.dq;
        h_nxt.dq_s2 = h_r.dq_s1;
        h_nxt.rd_ack = avs_read & ~h_r.rd_ack;
        // register writes
        if (avs_write && !cmd_stall) begin
            unique case (avs_address)
                nds_pkg::REG_CMD: begin
                    refuse = ((c == nds_pkg::CMD_READ_STATUS_ENH)
                        && (h_r.mode[nds_pkg::MODEF_OTP] || h_r.reset_lock))
                        || ((c == nds_pkg::CMD_READ_STATUS)
                        && h_r.mode[nds_pkg::MODEF_MULTI_LUN]);
                    if (refuse) begin
                        h_nxt.refused = 1'b1;
                    end else begin
                        h_nxt.cmd = c;
                        h_nxt.with_addr = avs_writedata[nds_pkg::CMDF_WITH_ADDR];
                        h_nxt.do_read = avs_writedata[nds_pkg::CMDF_DO_READ];
                        h_nxt.st = H_CMD;
                        h_nxt.cnt = nds_pkg::CNT_W'(nds_pkg::STROBE_CYC - 1);
                        h_nxt.half = 1'b0;
                        h_nxt.idx = '0;
                        if (c == nds_pkg::CMD_RESET) begin
                            h_nxt.reset_lock = 1'b1;
                        end
                    end
                end
                nds_pkg::REG_ROW: h_nxt.row = avs_writedata[nds_pkg::ROW_W-1:0];
                nds_pkg::REG_MODE: h_nxt.mode = avs_writedata[3:0];
                nds_pkg::REG_STAT: begin
                    if (avs_writedata[nds_pkg::STATF_REFUSED]) begin
                        h_nxt.refused = h_nxt.refused & refuse_now_unused();
                    end
                end
                default: begin
                end
            endcase
        end
        // bus sequencer
        h_nxt.cnt = (h_nxt.st == h_r.st && busy && !strobe_end) ? h_r.cnt - 1'b1 : h_nxt.cnt;
        unique case (h_r.st)
            H_IDLE: begin
                h_nxt.ce_n = ~(h_nxt.st != H_IDLE);
                h_nxt.cle = 1'b0;
                h_nxt.ale = 1'b0;
                h_nxt.we_n = 1'b1;
                h_nxt.re_n = 1'b1;
                h_nxt.wr_n = 1'b1;
                h_nxt.dq_oe = 1'b0;
            end
            H_CMD, H_ADDR: begin
                h_nxt.ce_n = 1'b0;
                h_nxt.cle = (h_r.st == H_CMD);
                h_nxt.ale = (h_r.st == H_ADDR);
                h_nxt.dq_oe = 1'b1;
                h_nxt.dq_o = (h_r.st == H_CMD) ? h_r.cmd : h_r.row[8*h_r.idx +: 8];
                h_nxt.we_n = h_r.half;
                if (strobe_end) begin
                    h_nxt.cnt = nds_pkg::CNT_W'(nds_pkg::STROBE_CYC - 1);
                    h_nxt.half = ~h_r.half;
                    if (h_r.half) begin
                        h_nxt.idx = (h_r.st == H_ADDR) ? h_r.idx + 2'd1 : '0;
                        if (h_r.st == H_CMD && h_r.with_addr) begin
                            h_nxt.st = H_ADDR;
                        end else if (h_r.st == H_ADDR
                            && h_r.idx != 2'(nds_pkg::ROW_CYCLES - 1)) begin
                            h_nxt.st = H_ADDR;
                        end else if (h_r.do_read) begin
                            h_nxt.st = H_READ;
                            h_nxt.cnt = nds_pkg::CNT_W'(nds_pkg::READ_CYC - 1);
                        end else begin
                            h_nxt.st = H_IDLE;
                        end
                    end
                end
            end
            H_READ: begin
                // async uses re_n, sync uses wr_n low with ale and cle high
                h_nxt.ce_n = 1'b0;
                h_nxt.dq_oe = 1'b0;
                h_nxt.we_n = 1'b1;
                h_nxt.re_n = h_r.mode[nds_pkg::MODEF_SYNC];
                h_nxt.wr_n = ~h_r.mode[nds_pkg::MODEF_SYNC];
                h_nxt.ale = h_r.mode[nds_pkg::MODEF_SYNC];
                h_nxt.cle = h_r.mode[nds_pkg::MODEF_SYNC];
                if (strobe_end) begin
                    h_nxt.last_byte = h_r.dq_s2;
                    h_nxt.st = H_IDLE;
                    if (h_r.dq_s2[nds_pkg::SB_DIE_IDLE]) begin
                        h_nxt.reset_lock = 1'b0;
                    end
                end
            end
            default: h_nxt.st = H_IDLE;
        endcase
        // register reads
        h_nxt.rdata = '0;
        unique case (avs_address)
            nds_pkg::REG_CMD: h_nxt.rdata = {22'h00_0000, h_r.do_read, h_r.with_addr, h_r.cmd};
            nds_pkg::REG_ROW: h_nxt.rdata = {8'h00, h_r.row};
            nds_pkg::REG_MODE: h_nxt.rdata = {28'h000_0000, h_r.mode};
            nds_pkg::REG_STAT: h_nxt.rdata = {16'h0000, h_r.last_byte, 5'h00,
                h_r.reset_lock, h_r.refused, busy};
            default: h_nxt.rdata = '0;
        endcase
    end

    // always returns zero, so a write to the refused bit always clears the flag
    function automatic logic refuse_now_unused();
        return 1'b0;
    endfunction : refuse_now_unused

    ////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            h_r <= '0;
            h_r.st <= H_IDLE;
            h_r.ce_n <= 1'b1;
            h_r.we_n <= 1'b1;
            h_r.re_n <= 1'b1;
            h_r.wr_n <= 1'b1;
            h_r.mode <= 4'h4;
        end else begin
            h_r <= h_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign avs_readdata = h_r.rdata;
    assign bus.ce_n = h_r.ce_n;
    assign bus.cle = h_r.cle;
    assign bus.ale = h_r.ale;
    assign bus.we_n = h_r.we_n;
    assign bus.re_n = h_r.re_n;
    assign bus.wr_n = h_r.wr_n;
    assign bus.wp_n = h_r.mode[nds_pkg::MODEF_WP_N];
    assign bus.host_dq_o = h_r.dq_o;
    assign bus.host_dq_oe = h_r.dq_oe;
endmodule : nds_host
`default_nettype wire
